// ===== verilog/ssfe_regs.svh
`ifndef SSFE_REGS_SVH
`define SSFE_REGS_SVH

// Register byte offsets
`define SSFE_A_CR      8'h00
`define SSFE_A_RCMR    8'h10
`define SSFE_A_RFMR    8'h14
`define SSFE_A_TCMR    8'h18
`define SSFE_A_TFMR    8'h1c
`define SSFE_A_RHR     8'h20
`define SSFE_A_THR     8'h24
`define SSFE_A_RSHR    8'h30
`define SSFE_A_TSHR    8'h34
`define SSFE_A_RC0     8'h38
`define SSFE_A_RC1     8'h3c
`define SSFE_A_SR      8'h40
`define SSFE_A_IER     8'h44
`define SSFE_A_IDR     8'h48
`define SSFE_A_IMR     8'h4c

// Command register bits
`define SSFE_CR_RXEN   0
`define SSFE_CR_RX_DISABLE_CMD  1
`define SSFE_CR_TXEN   8
`define SSFE_CR_TXDIS  9

// Clock mode fields
`define SSFE_F_START   11:8
`define SSFE_F_STOP    12
`define SSFE_F_DLY     23:16
`define SSFE_F_PER     31:24

// Frame mode fields
`define SSFE_F_WLEN    4:0
`define SSFE_F_DEF     5
`define SSFE_F_LOOP    5
`define SSFE_F_MSB_FIRST_SELECT    7
`define SSFE_F_WNUM    11:8
`define SSFE_F_SLEN    23:16
`define SSFE_F_SHAPE   26:24
`define SSFE_F_SDEN    27
`define SSFE_F_EDGE    28

// Status bits
`define SSFE_SR_W      6
`define SSFE_SR_TXFREE 0
`define SSFE_SR_TXEMP  1
`define SSFE_SR_RX_WORD_AVAILABLE_FLAG  2
`define SSFE_SR_OVR    3
`define SSFE_SR_TX_SYNC_SEEN_FLAG  4
`define SSFE_SR_RX_SYNC_SEEN_FLAG  5
`define SSFE_SR_TXEN   16
`define SSFE_SR_RXEN   17

// Start selections
`define SSFE_M_CONT    4'h0
`define SSFE_M_SYNC    4'h1
`define SSFE_M_FALL    4'h2
`define SSFE_M_RISE    4'h3
`define SSFE_M_LOW     4'h4
`define SSFE_M_HIGH    4'h5
`define SSFE_M_ANY     4'h6
`define SSFE_M_CMP     4'h7

// Frame sync output shapes
`define SSFE_FS_NONE   3'h0
`define SSFE_FS_NPUL   3'h1
`define SSFE_FS_PPUL   3'h2
`define SSFE_FS_LOWD   3'h3
`define SSFE_FS_HIGD   3'h4
`define SSFE_FS_TOGL   3'h5

// Limits and masks
`define SSFE_SLEN_CAP  8'h0f
`define SSFE_SYNC_MAX  5'h10
`define SSFE_WMAX      5'h1f
`define SSFE_ALL1      32'hffff_ffff
`define SSFE_CMP_ALL1  16'hffff

`endif

// ===== verilog/ssfe_pkg.sv
package ssfe_pkg;

  typedef enum logic [1:0] {DS_IDLE, DS_DELAY, DS_DATA} ssfe_dir_e;

  typedef struct packed {
    ssfe_dir_e   st;
    logic [7:0]  dly;
    logic [4:0]  bits;
    logic [3:0]  words;
    logic [8:0]  per;
    logic [8:0]  fsc;
    logic        tog;
    logic        fsp;
    logic [31:0] sh;
    logic [15:0] ssh;
    logic [4:0]  scnt;
  } ssfe_dir_s;

  typedef struct packed {
    logic [31:0] tcm;
    logic [31:0] tff;
    logic [31:0] rcm;
    logic [31:0] rff;
    logic [15:0] cmp0;
    logic [15:0] cmp1;
    logic [15:0] tsh;
    logic [15:0] rsh;
    logic [15:0] hist;
    logic [31:0] tx_hold;
    logic [31:0] rx_hold;
    logic [31:0] rdata;
    logic [5:0]  imr;
    logic [1:0]  ckp;
    logic        hold_full;
    logic        rx_avail;
    logic        ovr;
    logic        tx_syn;
    logic        rx_syn;
    logic        tx_en;
    logic        rx_en;
    logic        tx_dis_p;
    logic        rx_dis_p;
    logic        armed;
    logic        crun;
    logic        txq;
    logic        rxq;
    logic        tx_out;
    logic        tx_fs;
    logic        rx_fs;
    logic        txoe;
    logic        rxoe;
    logic        irq;
    ssfe_dir_s   tx;
    ssfe_dir_s   rx;
  } ssfe_st_s;

endpackage

// ===== verilog/ssfe_sync.sv
`timescale 1ns/1ns
module ssfe_sync #(
  parameter int W = 5
) (
  // Clock, reset, enable
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  // Pins in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] m_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      m_reg <= '0;
      q     <= '0;
    end else if (ce) begin
      m_reg <= d;
      q     <= m_reg;
    end
  end
endmodule

// ===== verilog/ssfe_top.sv
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "ssfe_regs.svh"
// Summary of operation
// RL1 - Empty flag set when holding and shift registers both hold nothing.
// RL2 - Holding-to-shift transfer sets the holding-free flag.
// RL3 - Full received word moves to receive holding, sets word-available.
// RL4 - Word completing before holding read sets overrun and still overwrites.
// RL5 - Continuous start: transmit on written word, receive once enabled.
// RL6 - Start per direction: other side, edge, level, or any change.
// RL7 - Receiver may start on compare-zero match, checked every sample.
// RL8 - Pulse frame sync lasts one to 256 bit periods.
// RL9 - Frame sync pulses repeat with a programmable period up to 512.
// RL10 - Frame sync shape: low/high during data, pulse before, or toggle.
// RL11 - Sync tag received into and sent from sync holding, max 16 bits.
// RL12 - Sync tag sent only when enabled; data wins over long tags.
// RL13 - Short receive tag passes through the shift path into sync holding.
// RL14 - Programmed frame edge sets the matching sync-seen flag.
// RL15 - Compare length equals sync length capped at 16, newest bits.
// RL16 - Stop bit: rearm by rewriting compare zero, or run until compare one.
// RL17 - Start delay up to 255 bit periods before the first data bit.
// RL18 - Up to 32-bit words, 16 words per start, either bit order.
// RL19 - Serial output rests at a programmable level outside transfers.
// RL20 - Continuous transmit start never sends sync data.
// RL21 - Loop mode feeds receiver from transmitter data, frame and clock.
// RL22 - Enable writes set mask bits, disable writes clear them.
// RL23 - Interrupt output high while a pending flag has its mask set.
// RL24 - Receive disable during a word waits for that word to finish.
// RL25 - Holding write clears holding-free; holding read clears word-available.
// RL26 - Bit clock edges drive all serial work; flags live on the main clock.
module ssfe_top (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Serial link
  input  wire logic        tx_bit_clock_line,
  input  wire logic        rx_bit_clock_line,
  input  wire logic        rx_serial_in,
  input  wire logic        rx_frame_line_in,
  input  wire logic        tx_frame_line_in,
  output logic             tx_serial_out,
  output logic             tx_frame_line_out,
  output logic             tx_frame_line_oe,
  output logic             rx_frame_line_out,
  output logic             rx_frame_line_oe,
  // Interrupt
  output logic             irq
);
  import ssfe_pkg::*;

  ssfe_st_s    s_reg;
  ssfe_st_s    s_next;
  logic [4:0]  pq;
  logic        loop;
  logic        tx_tick;
  logic        rx_tick;
  logic        tx_fl;
  logic        rx_fl;
  logic        rx_b;
  logic        t_go;
  logic        r_go;
  logic        m0;
  logic        m1;
  logic [4:0]  tsl;
  logic [4:0]  rsl;
  logic [15:0] hist;
  logic [31:0] cur;
  logic [31:0] shn;
  logic [31:0] rv;

  // Pins pass two flops before anything looks at them
  ssfe_sync #(.W(5)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .d    ({tx_frame_line_in, rx_frame_line_in, rx_serial_in,
            rx_bit_clock_line, tx_bit_clock_line}),
    .q    (pq)
  );

  function automatic logic get_bit(input logic [31:0] v, input logic [4:0] wl,
                                   input logic msb);
    get_bit = msb ? v[wl] : v[0];
  endfunction

  function automatic logic [31:0] tx_shift(input logic [31:0] v, input logic msb);
    tx_shift = msb ? {v[30:0], 1'b0} : {1'b0, v[31:1]};
  endfunction

  function automatic logic [31:0] rx_ins(input logic [31:0] v, input logic b,
                                         input logic [4:0] wl, input logic msb);
    logic [31:0] t;
    t = msb ? {v[30:0], b} : {1'b0, v[31:1]};
    if (!msb) begin
      t[wl] = b;
    end
    rx_ins = t;
  endfunction

  function automatic logic [31:0] wmask(input logic [4:0] wl);
    wmask = `SSFE_ALL1 >> (`SSFE_WMAX - wl);
  endfunction

  function automatic logic [4:0] slen16(input logic [7:0] f);
    slen16 = (f >= `SSFE_SLEN_CAP) ? `SSFE_SYNC_MAX : (f[4:0] + 5'h1);
  endfunction

  function automatic logic cmp_ok(input logic [15:0] h, input logic [15:0] p,
                                  input logic [4:0] n);
    cmp_ok = (((h ^ p) & (`SSFE_CMP_ALL1 >> (`SSFE_SYNC_MAX - n))) == '0);
  endfunction

  function automatic logic start_hit(input logic [3:0] m, input logic lvl,
                                     input logic prev, input logic other);
    case (m)
      `SSFE_M_SYNC: start_hit = other;
      `SSFE_M_FALL: start_hit = prev & ~lvl;
      `SSFE_M_RISE: start_hit = ~prev & lvl;
      `SSFE_M_LOW:  start_hit = ~lvl;
      `SSFE_M_HIGH: start_hit = lvl;
      `SSFE_M_ANY:  start_hit = prev ^ lvl;
      default:      start_hit = 1'b0;
    endcase
  endfunction

  // Period counter and pulse length counter, one bit tick
  function automatic ssfe_dir_s fs_step(input ssfe_dir_s d, input logic [7:0] p,
                                        input logic [7:0] sl);
    ssfe_dir_s o;
    o = d;
    if (o.fsc != '0) begin
      o.fsc = o.fsc - 9'h1;
    end
    if (p != '0) begin
      if (d.per == '0) begin
        o.per = {p, 1'b1};
        o.fsc = {1'b0, sl} + 9'h1;
        o.tog = ~d.tog;
      end else begin
        o.per = d.per - 9'h1;
      end
    end
    fs_step = o;
  endfunction

  function automatic logic fs_gen(input logic [2:0] shape, input ssfe_dir_s d);
    case (shape)
      `SSFE_FS_NPUL: fs_gen = (d.fsc == '0);
      `SSFE_FS_PPUL: fs_gen = (d.fsc != '0);
      `SSFE_FS_LOWD: fs_gen = (d.st != DS_DATA);
      `SSFE_FS_HIGD: fs_gen = (d.st == DS_DATA);
      `SSFE_FS_TOGL: fs_gen = d.tog;
      default:       fs_gen = 1'b0;
    endcase
  endfunction

  function automatic logic [`SSFE_SR_W-1:0] status(input ssfe_st_s s);
    status = '0;
    status[`SSFE_SR_TXFREE] = ~s.hold_full;
    status[`SSFE_SR_TXEMP]  = ~s.hold_full & (s.tx.st == DS_IDLE);
    status[`SSFE_SR_RX_WORD_AVAILABLE_FLAG]  = s.rx_avail;
    status[`SSFE_SR_OVR]    = s.ovr;
    status[`SSFE_SR_TX_SYNC_SEEN_FLAG]  = s.tx_syn;
    status[`SSFE_SR_RX_SYNC_SEEN_FLAG]  = s.rx_syn;
  endfunction

  always_comb begin
    s_next = s_reg;
    loop   = s_reg.rff[`SSFE_F_LOOP];
    s_next.ckp = pq[1:0];
    tx_tick = s_reg.ckp[0] & ~pq[0];
    rx_tick = loop ? (~s_reg.ckp[0] & pq[0]) : (~s_reg.ckp[1] & pq[1]); // RL26 RL21
    tx_fl = (s_reg.tff[`SSFE_F_SHAPE] != `SSFE_FS_NONE) ? s_reg.tx_fs : pq[4];
    rx_fl = (s_reg.rff[`SSFE_F_SHAPE] != `SSFE_FS_NONE) ? s_reg.rx_fs : pq[3];
    rx_fl = loop ? tx_fl : rx_fl; // RL21
    rx_b  = loop ? s_reg.tx_out : pq[2]; // RL21
    tsl  = slen16(s_reg.tff[`SSFE_F_SLEN]);
    rsl  = slen16(s_reg.rff[`SSFE_F_SLEN]); // RL15
    hist = {s_reg.hist[14:0], rx_b};
    m0   = cmp_ok(hist, s_reg.cmp0, rsl); // RL15
    m1   = cmp_ok(hist, s_reg.cmp1, rsl);
    t_go = 1'b0;
    r_go = 1'b0;
    cur  = s_reg.tx.sh;
    shn  = s_reg.rx.sh;
    rv   = '0;

    // Read-side clears come first so a same-cycle event wins
    if (rd) begin
      if (addr == `SSFE_A_RHR) begin
        s_next.rx_avail = 1'b0; // RL25
      end
      if (addr == `SSFE_A_SR) begin
        s_next.ovr    = 1'b0;
        s_next.tx_syn = 1'b0;
        s_next.rx_syn = 1'b0;
      end
    end
    if (tx_tick) begin
      s_next.txq = 1'b0;
    end
    if (rx_tick) begin
      s_next.rxq = 1'b0;
    end

    // Transmitter
    // Last bit stands a full period; a stopped transmitter shows the level at once
    if (s_reg.tx.st == DS_IDLE && (tx_tick || !s_reg.tx_en)) begin
      s_next.tx_out = s_reg.tff[`SSFE_F_DEF]; // RL19
    end
    if (tx_tick) begin
      s_next.tx = fs_step(s_reg.tx, s_reg.tcm[`SSFE_F_PER], s_reg.tff[`SSFE_F_SLEN]); // RL8 RL9
      s_next.tx.fsp = tx_fl;
      if (start_hit(s_reg.tff[`SSFE_F_EDGE] ? `SSFE_M_FALL : `SSFE_M_RISE,
                    tx_fl, s_reg.tx.fsp, 1'b0)) begin
        s_next.tx_syn = 1'b1; // RL14
      end
      if (s_reg.tcm[`SSFE_F_START] == `SSFE_M_CONT) begin
        t_go = s_reg.hold_full; // RL5
      end else begin
        t_go = start_hit(s_reg.tcm[`SSFE_F_START], tx_fl, s_reg.tx.fsp, s_reg.txq); // RL6
      end
      unique case (s_reg.tx.st)
        DS_IDLE: begin
          if (s_reg.tx_en && t_go) begin
            s_next.tx.dly   = s_reg.tcm[`SSFE_F_DLY]; // RL17
            s_next.tx.scnt  = '0;
            s_next.tx.ssh   = s_reg.tsh;
            s_next.tx.bits  = '0;
            s_next.tx.words = '0;
            s_next.tx.st    = (s_reg.tcm[`SSFE_F_DLY] == '0) ? DS_DATA : DS_DELAY;
            s_next.rxq      = 1'b1;
          end
        end
        DS_DELAY: begin
          // Tag only fits inside the delay; longer tags lose to data
          if (s_reg.tff[`SSFE_F_SDEN] && s_reg.tx.scnt < tsl &&
              s_reg.tcm[`SSFE_F_START] != `SSFE_M_CONT) begin // RL12 RL20
            s_next.tx_out = s_reg.tx.ssh[4'(tsl - 5'h1)]; // RL11
          end else begin
            s_next.tx_out = s_reg.tff[`SSFE_F_DEF];
          end
          s_next.tx.ssh  = {s_reg.tx.ssh[14:0], 1'b0};
          s_next.tx.scnt = s_reg.tx.scnt + 5'h1;
          s_next.tx.dly  = s_reg.tx.dly - 8'h1;
          if (s_reg.tx.dly == 8'h1) begin
            s_next.tx.st = DS_DATA;
          end
        end
        DS_DATA: begin
          if (s_reg.tx.bits == '0 && !s_reg.hold_full) begin
            // Underrun ends the frame
            s_next.tx.st  = DS_IDLE;
            s_next.tx_out = s_reg.tff[`SSFE_F_DEF];
          end else begin
            if (s_reg.tx.bits == '0) begin
              cur = s_reg.tx_hold;
              s_next.hold_full = 1'b0; // RL2
            end
            s_next.tx_out = get_bit(cur, s_reg.tff[`SSFE_F_WLEN],
                                    s_reg.tff[`SSFE_F_MSB_FIRST_SELECT]); // RL18
            s_next.tx.sh = tx_shift(cur, s_reg.tff[`SSFE_F_MSB_FIRST_SELECT]);
            if (s_reg.tx.bits == s_reg.tff[`SSFE_F_WLEN]) begin
              s_next.tx.bits = '0;
              if (s_reg.tx.words == s_reg.tff[`SSFE_F_WNUM] || s_reg.tx_dis_p) begin
                s_next.tx.st    = DS_IDLE;
                s_next.tx.words = '0;
              end else begin
                s_next.tx.words = s_reg.tx.words + 4'h1; // RL18
              end
              if (s_reg.tx_dis_p) begin
                s_next.tx_en    = 1'b0;
                s_next.tx_dis_p = 1'b0;
              end
            end else begin
              s_next.tx.bits = s_reg.tx.bits + 5'h1;
            end
          end
        end
        default: s_next.tx.st = DS_IDLE;
      endcase
    end

    // Receiver
    if (rx_tick) begin
      s_next.rx = fs_step(s_reg.rx, s_reg.rcm[`SSFE_F_PER], s_reg.rff[`SSFE_F_SLEN]); // RL8 RL9
      s_next.rx.fsp = rx_fl;
      if (start_hit(s_reg.rff[`SSFE_F_EDGE] ? `SSFE_M_FALL : `SSFE_M_RISE,
                    rx_fl, s_reg.rx.fsp, 1'b0)) begin
        s_next.rx_syn = 1'b1; // RL14
      end
      if (s_reg.rx_en) begin
        s_next.hist = hist; // RL7
      end
      unique case (s_reg.rcm[`SSFE_F_START])
        `SSFE_M_CONT: r_go = 1'b1; // RL5
        `SSFE_M_CMP:  r_go = (s_reg.armed & m0) | s_reg.crun; // RL7 RL16
        default:      r_go = start_hit(s_reg.rcm[`SSFE_F_START], rx_fl,
                                       s_reg.rx.fsp, s_reg.rxq); // RL6
      endcase
      unique case (s_reg.rx.st)
        DS_IDLE: begin
          if (s_reg.rx_en && r_go) begin
            s_next.rx.dly   = s_reg.rcm[`SSFE_F_DLY]; // RL17
            s_next.rx.scnt  = '0;
            s_next.rx.bits  = '0;
            s_next.rx.words = '0;
            s_next.rx.st    = (s_reg.rcm[`SSFE_F_DLY] == '0) ? DS_DATA : DS_DELAY;
            s_next.txq      = 1'b1;
            s_next.armed    = 1'b0; // RL16
            s_next.crun     = s_reg.rcm[`SSFE_F_STOP] &
                              (s_reg.rcm[`SSFE_F_START] == `SSFE_M_CMP);
          end
        end
        DS_DELAY: begin
          if (s_reg.rx.scnt < rsl) begin
            s_next.rx.ssh  = {s_reg.rx.ssh[14:0], rx_b}; // RL11 RL13
            s_next.rx.scnt = s_reg.rx.scnt + 5'h1;
          end
          s_next.rx.dly = s_reg.rx.dly - 8'h1;
          if (s_reg.rx.dly == 8'h1) begin
            s_next.rx.st = DS_DATA;
            if (s_next.rx.scnt != '0) begin
              s_next.rsh = s_next.rx.ssh; // RL13
            end
          end
        end
        DS_DATA: begin
          shn = rx_ins(s_reg.rx.sh, rx_b, s_reg.rff[`SSFE_F_WLEN],
                       s_reg.rff[`SSFE_F_MSB_FIRST_SELECT]); // RL18
          s_next.rx.sh = shn;
          if (s_reg.rx.bits == s_reg.rff[`SSFE_F_WLEN]) begin
            s_next.rx_hold  = shn & wmask(s_reg.rff[`SSFE_F_WLEN]); // RL3 RL4
            s_next.ovr      = s_next.ovr | s_next.rx_avail; // RL4
            s_next.rx_avail = 1'b1; // RL3
            s_next.rx.bits  = '0;
            if (s_reg.rx.words == s_reg.rff[`SSFE_F_WNUM] || s_reg.rx_dis_p) begin
              s_next.rx.st    = DS_IDLE;
              s_next.rx.words = '0;
            end else begin
              s_next.rx.words = s_reg.rx.words + 4'h1;
            end
            if (s_reg.rx_dis_p) begin
              s_next.rx_en    = 1'b0; // RL24
              s_next.rx_dis_p = 1'b0;
            end
          end else begin
            s_next.rx.bits = s_reg.rx.bits + 5'h1;
          end
        end
        default: s_next.rx.st = DS_IDLE;
      endcase
      if (m1) begin
        s_next.crun = 1'b0; // RL16
      end
    end

    // Register writes
    if (wr) begin
      unique case (addr)
        `SSFE_A_CR: begin
          if (wdata[`SSFE_CR_RXEN] && !wdata[`SSFE_CR_RX_DISABLE_CMD]) begin
            s_next.rx_en = 1'b1;
          end
          if (wdata[`SSFE_CR_RX_DISABLE_CMD]) begin
            if (s_reg.rx.st == DS_DATA) begin
              s_next.rx_dis_p = 1'b1; // RL24
            end else begin
              s_next.rx_en = 1'b0;
              s_next.rx.st = DS_IDLE;
            end
          end
          if (wdata[`SSFE_CR_TXEN] && !wdata[`SSFE_CR_TXDIS]) begin
            s_next.tx_en = 1'b1;
          end
          if (wdata[`SSFE_CR_TXDIS]) begin
            if (s_reg.tx.st == DS_DATA) begin
              s_next.tx_dis_p = 1'b1;
            end else begin
              s_next.tx_en = 1'b0;
              s_next.tx.st = DS_IDLE;
            end
          end
        end
        `SSFE_A_RCMR: s_next.rcm = wdata;
        `SSFE_A_RFMR: s_next.rff = wdata;
        `SSFE_A_TCMR: s_next.tcm = wdata;
        `SSFE_A_TFMR: s_next.tff = wdata;
        `SSFE_A_THR: begin
          s_next.tx_hold   = wdata;
          s_next.hold_full = 1'b1; // RL25
        end
        `SSFE_A_TSHR: s_next.tsh = wdata[15:0];
        `SSFE_A_RC0: begin
          s_next.cmp0  = wdata[15:0];
          s_next.armed = 1'b1; // RL16
        end
        `SSFE_A_RC1: s_next.cmp1 = wdata[15:0];
        `SSFE_A_IER: s_next.imr = s_next.imr | wdata[`SSFE_SR_W-1:0]; // RL22
        `SSFE_A_IDR: s_next.imr = s_next.imr & ~wdata[`SSFE_SR_W-1:0]; // RL22
        default: ;
      endcase
    end

    // Read data, valid only in the cycle after the strobe
    if (rd) begin
      unique case (addr)
        `SSFE_A_RCMR: rv = s_reg.rcm;
        `SSFE_A_RFMR: rv = s_reg.rff;
        `SSFE_A_TCMR: rv = s_reg.tcm;
        `SSFE_A_TFMR: rv = s_reg.tff;
        `SSFE_A_RHR:  rv = s_reg.rx_hold;
        `SSFE_A_RSHR: rv = {16'h0, s_reg.rsh};
        `SSFE_A_TSHR: rv = {16'h0, s_reg.tsh};
        `SSFE_A_RC0:  rv = {16'h0, s_reg.cmp0};
        `SSFE_A_RC1:  rv = {16'h0, s_reg.cmp1};
        `SSFE_A_SR: begin
          rv[`SSFE_SR_W-1:0] = status(s_reg); // RL1
          rv[`SSFE_SR_TXEN]  = s_reg.tx_en;
          rv[`SSFE_SR_RXEN]  = s_reg.rx_en;
        end
        `SSFE_A_IMR:  rv[`SSFE_SR_W-1:0] = s_reg.imr;
        default:      rv = '0;
      endcase
    end
    s_next.rdata = rv;

    // Pin drivers and interrupt, all registered
    s_next.tx_fs = fs_gen(s_next.tff[`SSFE_F_SHAPE], s_next.tx); // RL10
    s_next.rx_fs = fs_gen(s_next.rff[`SSFE_F_SHAPE], s_next.rx); // RL10
    s_next.txoe  = (s_next.tff[`SSFE_F_SHAPE] != `SSFE_FS_NONE);
    s_next.rxoe  = (s_next.rff[`SSFE_F_SHAPE] != `SSFE_FS_NONE);
    s_next.irq   = |(status(s_next) & s_next.imr); // RL23
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign rdata             = s_reg.rdata;
  assign tx_serial_out     = s_reg.tx_out;
  assign tx_frame_line_out = s_reg.tx_fs;
  assign tx_frame_line_oe  = s_reg.txoe;
  assign rx_frame_line_out = s_reg.rx_fs;
  assign rx_frame_line_oe  = s_reg.rxoe;
  assign irq               = s_reg.irq;
endmodule

// ===== sim/ssfe_top_checker.sv
`timescale 1ns/1ns
`include "ssfe_regs.svh"
module ssfe_top_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // Outputs
  input wire logic        tx_serial_out,
  input wire logic        irq
);
  logic [5:0] wd_q;
  logic [5:0] m_q;
  logic       def_q;
  logic       txon_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // Shadows fed only from bus writes, never from the design
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wd_q <= 6'h00;
      m_q <= 6'h00;
      def_q <= 1'b0;
      txon_q <= 1'b0;
    end else if (wr) begin
      wd_q <= wdata[5:0];
      if (addr == `SSFE_A_IER) m_q <= m_q | wdata[5:0];
      if (addr == `SSFE_A_IDR) m_q <= m_q & ~wdata[5:0];
      if (addr == `SSFE_A_TFMR) def_q <= wdata[5];
      if (addr == `SSFE_A_CR) txon_q <= wdata[8] | (txon_q & ~wdata[9]);
    end
  end

  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside read answer");
  a_wo_zero: assert property (rd && (addr == `SSFE_A_CR || addr == `SSFE_A_THR
    || addr == 8'h08) |=> rdata == 32'h0) else $error("write-only or unmapped read not zero");
  a_ier_sets: assert property (wr && addr == `SSFE_A_IER ##2 rd && addr == `SSFE_A_IMR
    |=> (rdata[5:0] & wd_q) == wd_q) else $error("mask bits not set");
  a_idr_clears: assert property (wr && addr == `SSFE_A_IDR ##2 rd && addr == `SSFE_A_IMR
    |=> (rdata[5:0] & wd_q) == 6'h00) else $error("mask bits not cleared");
  a_irq_masked: assert property (irq |-> m_q != 6'h0 || $past(m_q) != 6'h0)
    else $error("interrupt with empty mask");
  a_thr_clears_free: assert property (wr && addr == `SSFE_A_THR ##2 rd && addr == `SSFE_A_SR
    |=> !rdata[`SSFE_SR_TXFREE]) else $error("holding free after write");
  a_sticky_clear: assert property (rd && addr == `SSFE_A_SR ##2 rd && addr == `SSFE_A_SR
    |=> rdata[5:3] == 3'h0) else $error("sticky flags survive status read");
  a_idle_level: assert property (wr && addr == `SSFE_A_TFMR && !txon_q
    |-> ##4 tx_serial_out == def_q) else $error("serial out not at idle level");

  cover property (irq);
  cover property (rd && addr == `SSFE_A_RHR);
  cover property ($rose(tx_serial_out));
endmodule

// ===== sim/ssfe_codec_model.sv
`timescale 1ns/1ns
module ssfe_codec_model (
  // Serial link
  output logic bclk,
  output logic fs,
  output logic sd
);
  initial begin
    bclk = 1'b0;
    fs = 1'b0;
    sd = 1'b0;
  end

  // Sync slot, eight data bits msb first, trailing slots; clock idles low
  task automatic frame(input logic [7:0] w);
    for (int i = 0; i < 12; i++) begin
      fs <= (i == 0);
      sd <= (i > 0 && i < 9) ? w[8-i] : ~sd;
      #400 bclk <= 1'b1;
      #400 bclk <= 1'b0;
    end
  endtask
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ns
`include "ssfe_regs.svh"
module testbench;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        bclk;
  logic        fs;
  logic        sd;
  logic        tx_serial_out;
  logic        irq;
  logic        tfo;
  logic        tfe;
  logic        rfo;
  logic        rfe;
  int          err_total = 0;
  int          n_compared = 0;
  int          cyc = 0;

  always #50 clk = ~clk;

  ssfe_top DUT (.clk(clk), .nrst(nrst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .tx_bit_clock_line(bclk), .rx_bit_clock_line(bclk),
    .rx_serial_in(sd), .rx_frame_line_in(fs), .tx_frame_line_in(fs),
    .tx_serial_out(tx_serial_out), .tx_frame_line_out(tfo), .tx_frame_line_oe(tfe),
    .rx_frame_line_out(rfo), .rx_frame_line_oe(rfe), .irq(irq));
  ssfe_codec_model codec (.bclk(bclk), .fs(fs), .sd(sd));

  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata & m, e);
  endtask

  task automatic t_bus();
    rd_chk(`SSFE_A_SR, 32'h3f, 32'h03);
    rd_chk(8'h08, 32'hffff_ffff, 32'h0);
    rd_chk(`SSFE_A_THR, 32'hffff_ffff, 32'h0);
  endtask

  task automatic t_mask();
    wr_reg(`SSFE_A_IER, 32'h3f);
    rd_chk(`SSFE_A_IMR, 32'h3f, 32'h3f);
    wr_reg(`SSFE_A_IDR, 32'h3e);
    rd_chk(`SSFE_A_IMR, 32'h3f, 32'h01);
    chk({31'h0, irq}, 32'h1);
    wr_reg(`SSFE_A_IDR, 32'h01);
    rd_chk(`SSFE_A_IMR, 32'h3f, 32'h00);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_rx();
    wr_reg(`SSFE_A_RCMR, 32'h300);
    wr_reg(`SSFE_A_RFMR, 32'h87);
    wr_reg(`SSFE_A_CR, 32'h1);
    codec.frame(8'ha5);
    codec.frame(8'h3c);
    rd_chk(`SSFE_A_SR, 32'h2c, 32'h2c);
    rd_chk(`SSFE_A_SR, 32'h2c, 32'h04);
    rd_chk(`SSFE_A_RHR, 32'hff, 32'h3c);
    rd_chk(`SSFE_A_SR, 32'h04, 32'h00);
  endtask

  task automatic t_loop();
    wr_reg(`SSFE_A_TFMR, 32'h20);
    repeat (6) @(posedge clk);
    chk({31'h0, tx_serial_out}, 32'h1);
    wr_reg(`SSFE_A_TFMR, 32'h0400_0087);
    wr_reg(`SSFE_A_RCMR, 32'h100);
    wr_reg(`SSFE_A_RFMR, 32'ha7);
    wr_reg(`SSFE_A_CR, 32'h100);
    wr_reg(`SSFE_A_THR, 32'h5b);
    rd_chk(`SSFE_A_SR, 32'h03, 32'h00);
    chk({28'h0, rfe, rfo, tfe, tfo}, 32'h2);
    codec.frame(8'hc3);
    rd_chk(`SSFE_A_SR, 32'h07, 32'h07);
    rd_chk(`SSFE_A_RHR, 32'hff, 32'h5b);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_bus();
    t_mask();
    t_rx();
    t_loop();
    close_out();
  end

  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
endmodule

bind ssfe_top ssfe_top_checker chk_i (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata,
  .tx_serial_out, .irq);
